// ===== design/hbp_pkg.sv
// Package of constants for the host bus port and interrupt block.
package hbp_pkg;

    // ************************************************************
    // Register map (byte addresses on the AXI4-Lite slave)
    // ************************************************************
    localparam logic [7:0] HBP_ADDR_STATUS0 = 8'h00;
    localparam logic [7:0] HBP_ADDR_STATUS3 = 8'h0c;
    localparam logic [7:0] HBP_ADDR_MASK0 = 8'h10;
    localparam logic [7:0] HBP_ADDR_MASK3 = 8'h1c;
    localparam logic [7:0] HBP_ADDR_SUMMARY = 8'h20;
    localparam logic [7:0] HBP_ADDR_PIN_CFG = 8'h24;
    localparam logic [7:0] HBP_ADDR_RX_LEN = 8'h28;
    localparam logic [7:0] HBP_ADDR_BUS_STATE = 8'h2c;
    localparam logic [7:0] HBP_ADDR_RX_DATA = 8'h30;
    localparam logic [7:0] HBP_ADDR_TX_DATA = 8'h34;
    localparam logic [7:0] HBP_ADDR_HALF_SWAP = 8'h38;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int HBP_CFG_OPEN_DRAIN_BIT = 0;
    localparam int HBP_CFG_SHOW_BIT = 1;
    localparam logic [5:0] HBP_RX_LEN_RESET = 6'h20;
    localparam logic [5:0] HBP_RX_LEN_MIN = 6'h02;
    localparam logic [5:0] HBP_HALF_BYTES = 6'h20;
    localparam logic [1:0] HBP_RESP_OKAY = 2'h0;
    localparam logic [1:0] HBP_RESP_SLVERR = 2'h2;

    // ************************************************************
    // Bus protocol and lane choices
    // ************************************************************
    typedef enum logic [1:0] {HBP_DIR_DEMUX, HBP_STROBE_DEMUX, HBP_STROBE_MUX} hbp_proto_t;
    typedef enum logic [1:0] {HBP_LANE_NONE, HBP_LANE_LOW, HBP_LANE_HIGH, HBP_LANE_WORD} hbp_lane_t;

endpackage : hbp_pkg

// ===== design/hbp_top.sv
// Host bus port: lane steering, signaling queue window and interrupt aggregation.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Strobe style: high enable and A0 select word, upper odd, lower even, none.
// - Direction style: enable and A0 select word, lower odd, upper even, none.
// - Type select high is direction style; low picks strobe, muxed if latch toggles.
// - Each direction has 64-byte queue in two 32-byte halves, one CPU side.
// - Width strap high allows word queue access; byte access stays allowed.
// - Receive window length is programmable from 32 bytes down to 2.
// - One interrupt output, open-drain or push-pull by configuration.
// - Status registers clear on read and help release the interrupt.
// - Mask bit blocks interrupt and status display when show mode is off.
// - Non-maskable summary holds one bit per status register with unmasked events.
// - Summary clears after the status reads, or keeps showing remaining sources.
// - Interrupt goes inactive only when the summary is all zero.
// - Summary updates are held off during its read; a status read still loads events of the same cycle.
// - Show mode displays masked events without interrupt or summary bit.
// - In show mode a read clears all active bits; unmasked ones behave normally.
// - Mixed byte and word queue accesses are accepted in any order.
module hbp_top
    import hbp_pkg::*;
#(
    parameter int EVENT_BITS = 8,
    parameter int QUEUE_BYTES = 64
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bus style pins
    input wire logic bus_type_select,
    input wire logic latch_enable,
    input wire logic bus_width_strap,
    input wire logic high_lane_enable_n,
    input wire logic lane_select_n,
    input wire logic addr_bit0,
    // Internal event sources, one pulse per event
    input wire logic [EVENT_BITS-1:0] event_pulse [4],
    // Highway side of the queues
    input wire logic [7:0] hw_rx_byte,
    input wire logic hw_rx_write,
    input wire logic hw_tx_read,
    output logic [7:0] hw_tx_byte,
    // Interrupt pin
    output logic irq_out,
    output logic irq_oe,
    output logic irq
);

    if (EVENT_BITS < 1 || EVENT_BITS > 8 || QUEUE_BYTES != 2 * HBP_HALF_BYTES)
        $error("hbp_top: unsupported parameters");

    // ************************************************************
    // Pin synchronisers and bus style decode
    // ************************************************************
    logic [2:0] sel_sync_reg, ale_sync_reg, strap_sync_reg, hle_sync_reg, ls_sync_reg, a0_sync_reg;
    logic ale_toggled_reg;
    hbp_proto_t proto_reg;
    hbp_lane_t lane_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_sync_reg <= 3'h0;
            ale_sync_reg <= 3'h0;
            strap_sync_reg <= 3'h0;
            hle_sync_reg <= 3'h7;
            ls_sync_reg <= 3'h7;
            a0_sync_reg <= 3'h0;
        end
        else
        begin
            sel_sync_reg <= {sel_sync_reg[1:0], bus_type_select};
            ale_sync_reg <= {ale_sync_reg[1:0], latch_enable};
            strap_sync_reg <= {strap_sync_reg[1:0], bus_width_strap};
            hle_sync_reg <= {hle_sync_reg[1:0], high_lane_enable_n};
            ls_sync_reg <= {ls_sync_reg[1:0], lane_select_n};
            a0_sync_reg <= {a0_sync_reg[1:0], addr_bit0};
        end
    end

    // A latch enable that changed once is taken as switching; it stays so until reset.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ale_toggled_reg <= 1'b0;
        else if (ale_sync_reg[2] != ale_sync_reg[1])
            ale_toggled_reg <= 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            proto_reg <= HBP_STROBE_DEMUX;
        else if (sel_sync_reg[2] == sel_sync_reg[1])
        begin
            if (sel_sync_reg[2])
                proto_reg <= HBP_DIR_DEMUX;
            else if (ale_toggled_reg)
                proto_reg <= HBP_STROBE_MUX;
            else
                proto_reg <= HBP_STROBE_DEMUX;
        end
    end

    function automatic hbp_lane_t hbp_lane_decode(input logic en_n, input logic a0,
                                                  input logic dir_style);
        hbp_lane_t l;
        l = HBP_LANE_NONE;
        unique case ({en_n, a0})
            2'b00: l = HBP_LANE_WORD;
            2'b01: l = dir_style ? HBP_LANE_LOW : HBP_LANE_HIGH;
            2'b10: l = dir_style ? HBP_LANE_HIGH : HBP_LANE_LOW;
            2'b11: l = HBP_LANE_NONE;
        endcase
        return l;
    endfunction : hbp_lane_decode

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            lane_reg <= HBP_LANE_NONE;
        else if (!strap_sync_reg[2])
            lane_reg <= HBP_LANE_LOW;
        else if (proto_reg == HBP_DIR_DEMUX)
        begin
            if (ls_sync_reg[2] == ls_sync_reg[1] && a0_sync_reg[2] == a0_sync_reg[1])
                lane_reg <= hbp_lane_decode(ls_sync_reg[2], a0_sync_reg[2], 1'b1);
        end
        else if (hle_sync_reg[2] == hle_sync_reg[1] && a0_sync_reg[2] == a0_sync_reg[1])
            lane_reg <= hbp_lane_decode(hle_sync_reg[2], a0_sync_reg[2], 1'b0);
    end

    // ************************************************************
    // AXI4-Lite handshake
    // ************************************************************
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write, do_read;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= HBP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_ok(aw_addr_reg) ? HBP_RESP_OKAY : HBP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    function automatic logic write_ok(input logic [7:0] a);
        return (a >= HBP_ADDR_MASK0 && a <= HBP_ADDR_MASK3 && a[1:0] == 2'h0)
            || a == HBP_ADDR_PIN_CFG || a == HBP_ADDR_RX_LEN
            || a == HBP_ADDR_TX_DATA || a == HBP_ADDR_HALF_SWAP;
    endfunction : write_ok

    // ************************************************************
    // Interrupt status, mask, summary
    // ************************************************************
    logic [EVENT_BITS-1:0] status_reg [4];
    logic [EVENT_BITS-1:0] mask_reg [4];
    logic [1:0] pin_cfg_reg;
    logic [3:0] summary_reg;
    logic [3:0] status_read;
    logic summary_read;

    assign summary_read = do_read && s_axi_araddr == HBP_ADDR_SUMMARY;

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_irq
            logic [EVENT_BITS-1:0] shown;
            assign status_read[g] = do_read && s_axi_araddr == HBP_ADDR_STATUS0 + 8'(4 * g);
            // Masked events are dropped unless the show mode keeps them.
            assign shown = event_pulse[g] & (~mask_reg[g] |
                {EVENT_BITS{pin_cfg_reg[HBP_CFG_SHOW_BIT]}});
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    status_reg[g] <= '0;
                else if (status_read[g])
                    status_reg[g] <= shown;
                else
                    status_reg[g] <= status_reg[g] | shown;
            end
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    mask_reg[g] <= '0;
                else if (do_write && aw_addr_reg == HBP_ADDR_MASK0 + 8'(4 * g) && w_strb_reg[0])
                    mask_reg[g] <= w_data_reg[EVENT_BITS-1:0];
            end
            // Summary follows unmasked pending bits; it is frozen during its own read.
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    summary_reg[g] <= 1'b0;
                else if (!summary_read)
                    summary_reg[g] <= |(status_reg[g] & ~mask_reg[g]);
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pin_cfg_reg <= 2'h0;
        else if (do_write && aw_addr_reg == HBP_ADDR_PIN_CFG && w_strb_reg[0])
            pin_cfg_reg <= w_data_reg[1:0];
    end

    // Open drain only pulls low; push-pull drives both levels with active-low sense.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq <= 1'b0;
            irq_out <= 1'b1;
            irq_oe <= 1'b0;
        end
        else
        begin
            irq <= |summary_reg;
            irq_out <= ~|summary_reg;
            irq_oe <= !pin_cfg_reg[HBP_CFG_OPEN_DRAIN_BIT] || |summary_reg;
        end
    end

    // ************************************************************
    // Signaling queues: two halves each way
    // ************************************************************
    logic [7:0] rx_mem [QUEUE_BYTES];
    logic [7:0] tx_mem [QUEUE_BYTES];
    logic rx_half_reg, tx_half_reg;
    logic [4:0] rx_cpu_ptr_reg, rx_hw_ptr_reg, tx_cpu_ptr_reg, tx_hw_ptr_reg;
    logic [5:0] rx_len_reg;
    logic rx_data_read, tx_data_write, word_access;

    assign rx_data_read = do_read && s_axi_araddr == HBP_ADDR_RX_DATA;
    assign tx_data_write = do_write && aw_addr_reg == HBP_ADDR_TX_DATA;
    assign word_access = lane_reg == HBP_LANE_WORD && strap_sync_reg[2];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_len_reg <= HBP_RX_LEN_RESET;
        else if (do_write && aw_addr_reg == HBP_ADDR_RX_LEN && w_strb_reg[0])
        begin
            if (w_data_reg[5:0] < HBP_RX_LEN_MIN)
                rx_len_reg <= HBP_RX_LEN_MIN;
            else if (w_data_reg[5:0] > HBP_RX_LEN_RESET)
                rx_len_reg <= HBP_RX_LEN_RESET;
            else
                rx_len_reg <= w_data_reg[5:0];
        end
    end

    // A swap write hands the CPU the other half of the selected direction.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_half_reg <= 1'b0;
            tx_half_reg <= 1'b0;
        end
        else if (do_write && aw_addr_reg == HBP_ADDR_HALF_SWAP)
        begin
            rx_half_reg <= rx_half_reg ^ w_data_reg[0];
            tx_half_reg <= tx_half_reg ^ w_data_reg[1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (hw_rx_write)
            rx_mem[{~rx_half_reg, rx_hw_ptr_reg}] <= hw_rx_byte;
        if (tx_data_write)
        begin
            tx_mem[{tx_half_reg, tx_cpu_ptr_reg}] <= w_data_reg[7:0];
            if (word_access)
                tx_mem[{tx_half_reg, tx_cpu_ptr_reg + 5'h01}] <= w_data_reg[15:8];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_cpu_ptr_reg <= 5'h00;
            rx_hw_ptr_reg <= 5'h00;
            tx_cpu_ptr_reg <= 5'h00;
            tx_hw_ptr_reg <= 5'h00;
            hw_tx_byte <= 8'h00;
        end
        else
        begin
            if (hw_rx_write)
                rx_hw_ptr_reg <= rx_hw_ptr_reg + 5'h01;
            if (rx_data_read)
                rx_cpu_ptr_reg <= 5'((6'(rx_cpu_ptr_reg) + (word_access ? 6'h02 : 6'h01))
                    % rx_len_reg);
            if (tx_data_write)
                tx_cpu_ptr_reg <= tx_cpu_ptr_reg + (word_access ? 5'h02 : 5'h01);
            if (hw_tx_read)
            begin
                hw_tx_byte <= tx_mem[{~tx_half_reg, tx_hw_ptr_reg}];
                tx_hw_ptr_reg <= tx_hw_ptr_reg + 5'h01;
            end
        end
    end

    // ************************************************************
    // Read data path
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= HBP_RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= HBP_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr <= HBP_ADDR_STATUS3 && s_axi_araddr[1:0] == 2'h0)
                s_axi_rdata[EVENT_BITS-1:0] <= status_reg[s_axi_araddr[3:2]];
            else if (s_axi_araddr >= HBP_ADDR_MASK0 && s_axi_araddr <= HBP_ADDR_MASK3
                     && s_axi_araddr[1:0] == 2'h0)
                s_axi_rdata[EVENT_BITS-1:0] <= mask_reg[s_axi_araddr[3:2]];
            else if (summary_read)
                s_axi_rdata[3:0] <= summary_reg;
            else if (s_axi_araddr == HBP_ADDR_PIN_CFG)
                s_axi_rdata[1:0] <= pin_cfg_reg;
            else if (s_axi_araddr == HBP_ADDR_RX_LEN)
                s_axi_rdata[5:0] <= rx_len_reg;
            else if (s_axi_araddr == HBP_ADDR_BUS_STATE)
                s_axi_rdata[6:0] <= {tx_half_reg, rx_half_reg, strap_sync_reg[2], lane_reg,
                    proto_reg};
            else if (rx_data_read)
            begin
                s_axi_rdata[7:0] <= rx_mem[{rx_half_reg, rx_cpu_ptr_reg}];
                if (word_access)
                    s_axi_rdata[15:8] <= rx_mem[{rx_half_reg, rx_cpu_ptr_reg + 5'h01}];
            end
            else
                s_axi_rresp <= HBP_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : hbp_top

// ===== tb/hbp_checker.sv
// Concurrent checks on the host bus port top-level ports.
`timescale 1ns/1ps
module hbp_checker
    import hbp_pkg::*;
#(
    parameter int EVENT_BITS = 8
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Observed ports
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [EVENT_BITS-1:0] event_pulse [4],
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic irq
);
    logic [3:0] since_ev;
    logic [3:0] since_rd;
    logic any_ev;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    always_comb any_ev = (|event_pulse[0]) | (|event_pulse[1]) | (|event_pulse[2])
        | (|event_pulse[3]);
    // Saturating ages let the interrupt edges be tied to their causes.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n) since_ev <= 4'hf;
        else if (any_ev) since_ev <= 4'h0;
        else if (since_ev != 4'hf) since_ev <= since_ev + 4'h1;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n) since_rd <= 4'hf;
        else if (s_axi_arvalid && s_axi_arready) since_rd <= 4'h0;
        else if (since_rd != 4'hf) since_rd <= since_rd + 4'h1;
    end
    a_pin_level_low: assert property (irq_out == !irq)
        else $error("irq pin level disagrees with irq");
    a_oe_when_active: assert property (irq |-> irq_oe)
        else $error("asserted irq pin not driven");
    a_irq_rise_cause: assert property ($rose(irq) |-> since_ev <= 4'h6)
        else $error("irq rose without a recent event");
    a_irq_fall_read: assert property ($fell(irq) |-> since_rd <= 4'h6)
        else $error("irq fell without a recent read");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
endmodule : hbp_checker
bind hbp_top hbp_checker #(.EVENT_BITS(EVENT_BITS)) u_chk (.clk(clk), .reset_n(reset_n),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .event_pulse(event_pulse), .irq_out(irq_out), .irq_oe(irq_oe), .irq(irq));

// ===== tb/hbp_pin_model.sv
// Model of the host pins and highway writer that face the port.
`timescale 1ns/1ps
module hbp_pin_model (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic dir_style,
    input wire logic mux_style,
    input wire logic wide,
    input wire logic en_n,
    input wire logic a0,
    input wire logic push,
    input wire logic [7:0] push_byte,
    // Pins and highway side
    output logic bus_type_select,
    output logic latch_enable,
    output logic bus_width_strap,
    output logic high_lane_enable_n,
    output logic lane_select_n,
    output logic addr_bit0,
    output logic [7:0] hw_rx_byte,
    output logic hw_rx_write
);
    logic [7:0] last;
    initial latch_enable = 1'b0;
    initial last = 8'h00;
    // A multiplexed host toggles the latch strobe on every cycle.
    always @(posedge clk)
    begin
        if (mux_style) latch_enable <= !latch_enable;
        if (push) last <= push_byte;
    end
    assign bus_type_select = dir_style;
    assign high_lane_enable_n = dir_style ? 1'b1 : en_n;
    assign lane_select_n = dir_style ? en_n : 1'b1;
    assign addr_bit0 = a0;
    assign bus_width_strap = wide;
    assign hw_rx_write = push;
    // An idle byte bus shows no stale value.
    assign hw_rx_byte = push ? push_byte : ~last;
endmodule : hbp_pin_model

// ===== tb/hbp_top_tb_top.sv
// Self-checking bench for the host bus port and interrupt block.
`timescale 1ns/1ps
module hbp_top_tb_top;
    import hbp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] ev [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic dir_s = 1'b1, mux_s = 1'b0, wide = 1'b1, en_n = 1'b0, a0 = 1'b0, push = 1'b0;
    logic [7:0] pbyte = 8'h00;
    logic tx_rd = 1'b0;
    logic bts, le, bws, hle_n, ls_n, ab0, rxw, irq_out, irq_oe, irq;
    logic [7:0] rxb, txb;
    logic [31:0] d;
    logic [1:0] r;
    int num_errors = 0, n_compared = 0, cyc = 0, i;
    always #25 clk = ~clk;
    hbp_pin_model pins (.clk(clk), .dir_style(dir_s), .mux_style(mux_s), .wide(wide),
        .en_n(en_n), .a0(a0), .push(push), .push_byte(pbyte), .bus_type_select(bts),
        .latch_enable(le), .bus_width_strap(bws), .high_lane_enable_n(hle_n),
        .lane_select_n(ls_n), .addr_bit0(ab0), .hw_rx_byte(rxb), .hw_rx_write(rxw));
    hbp_top #(.EVENT_BITS(8)) uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus_type_select(bts), .latch_enable(le),
        .bus_width_strap(bws), .high_lane_enable_n(hle_n), .lane_select_n(ls_n),
        .addr_bit0(ab0), .event_pulse(ev), .hw_rx_byte(rxb), .hw_rx_write(rxw),
        .hw_tx_read(tx_rd), .hw_tx_byte(txb), .irq_out(irq_out), .irq_oe(irq_oe), .irq(irq));
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin resp = bresp; bready <= 1'b0; break; end
        end
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin v = rdata; resp = rresp; rready <= 1'b0; break; end
        end
    endtask : rd
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task pulse(input int k, input logic [7:0] v);
        @(posedge clk) ev[k] <= v;
        @(posedge clk) ev[k] <= 8'h00;
        repeat (5) @(posedge clk);
    endtask : pulse
    task test_done;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000) begin num_errors++; test_done(); end
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(HBP_ADDR_RX_LEN, d, r); chk(d[5:0], HBP_RX_LEN_RESET, "rx len reset");
        chk({irq, irq_out, irq_oe}, 3'b011, "irq idle");
        wr(HBP_ADDR_RX_LEN, 32'h1, r); rd(HBP_ADDR_RX_LEN, d, r);
        chk(d[5:0], HBP_RX_LEN_MIN, "rx len floor");
        wr(HBP_ADDR_RX_LEN, 32'h3f, r); rd(HBP_ADDR_RX_LEN, d, r);
        chk(d[5:0], 6'h20, "rx len ceiling");
        rd(8'hfc, d, r); chk(r, HBP_RESP_SLVERR, "unmapped read");
        wr(HBP_ADDR_SUMMARY, 32'hf, r); chk(r, HBP_RESP_SLVERR, "read-only write");
        $display("test registers done");
        pulse(0, 8'h01); pulse(3, 8'h80);
        chk(irq, 1'b1, "irq raised");
        rd(HBP_ADDR_SUMMARY, d, r); chk(d[3:0], 4'h9, "summary two");
        rd(HBP_ADDR_STATUS0, d, r); chk(d[7:0], 8'h01, "status0");
        rd(HBP_ADDR_STATUS0, d, r); chk(d[7:0], 8'h00, "status0 cleared");
        rd(HBP_ADDR_SUMMARY, d, r); chk(d[3:0], 4'h8, "summary updated");
        chk(irq, 1'b1, "irq still pending");
        rd(HBP_ADDR_STATUS3, d, r); chk(d[7:0], 8'h80, "status3");
        repeat (4) @(posedge clk);
        chk(irq, 1'b0, "irq released");
        rd(HBP_ADDR_SUMMARY, d, r); chk(d[3:0], 4'h0, "summary cleared");
        $display("test interrupt done");
        wr(HBP_ADDR_MASK0 + 8'h08, 32'h1, r); pulse(2, 8'h01);
        chk(irq, 1'b0, "masked no irq");
        rd(HBP_ADDR_MASK0 + 8'h08, d, r); chk(d[7:0], 8'h01, "mask readback");
        rd(8'h08, d, r); chk(d[7:0], 8'h00, "masked hidden");
        wr(HBP_ADDR_PIN_CFG, 32'h3, r); pulse(2, 8'h03);
        chk({irq, irq_oe}, 2'b11, "show mode irq");
        rd(HBP_ADDR_SUMMARY, d, r); chk(d[3:0], 4'h4, "show summary");
        rd(8'h08, d, r); chk(d[7:0], 8'h03, "show status");
        rd(8'h08, d, r); chk(d[7:0], 8'h00, "show cleared");
        repeat (4) @(posedge clk);
        chk({irq, irq_out, irq_oe}, 3'b010, "open drain idle");
        $display("test masking done");
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk) dir_s <= (i < 4); en_n <= i[1]; a0 <= i[0];
            repeat (6) @(posedge clk);
            rd(HBP_ADDR_BUS_STATE, d, r);
            chk(d[4:0], {1'b1, (!i[1] && !i[0]) ? 2'h3 : (i[1] && i[0]) ? 2'h0 :
                ((i < 4) == i[1]) ? 2'h2 : 2'h1, (i < 4) ? 2'h0 : 2'h1}, "lane");
        end
        @(posedge clk) mux_s <= 1'b1; en_n <= 1'b0; a0 <= 1'b0;
        repeat (6) @(posedge clk) mux_s <= 1'b0;
        rd(HBP_ADDR_BUS_STATE, d, r); chk(d[4:0], 5'h1e, "muxed word");
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk) push <= 1'b1; pbyte <= 8'h11 * (i + 1);
            @(posedge clk) push <= 1'b0;
        end
        wr(HBP_ADDR_HALF_SWAP, 32'h1, r);
        rd(HBP_ADDR_RX_DATA, d, r); chk(d[15:0], 16'h2211, "rx word");
        @(posedge clk) a0 <= 1'b1;
        repeat (6) @(posedge clk);
        rd(HBP_ADDR_RX_DATA, d, r); chk(d[7:0], 8'h33, "rx byte");
        wr(HBP_ADDR_TX_DATA, 32'ha5, r); wr(HBP_ADDR_HALF_SWAP, 32'h2, r);
        @(posedge clk) tx_rd <= 1'b1;
        @(posedge clk) tx_rd <= 1'b0;
        @(posedge clk); chk(txb, 8'ha5, "tx byte");
        $display("test lanes and queues done");
        test_done();
    end
endmodule : hbp_top_tb_top
